// ---- adsp_fifo.sv ----
// adsp_fifo: small synchronous fifo with valid/ready on both sides
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/100ps
module adsp_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    assign inReady  = (count_r != (PW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = mem[rdPtr_r];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop)
            begin
                rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// ---- adsp_host_model.sv ----
// adsp_host_model: host side of the serial port, one frame per call
// assumes: chip-select mode, 8 command bits then 24 data bits
`timescale 1ns/100ps
module adsp_host_model (
    output logic      sclk,
    output logic      chipSelect_n,
    output logic      serial_in_line,
    input  wire logic serial_out_line
);
    initial
    begin
        sclk = 1'b0;
        chipSelect_n = 1'b1;
        serial_in_line = 1'b0;
    end

    // sclk only runs inside a frame
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd};
        rd = 24'h0;
        #7 chipSelect_n = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            serial_in_line = sh[i];
            #24 sclk = 1'b1;
            if (i < 24) rd[i] = serial_out_line;
            #24 sclk = 1'b0;
        end
        #24 chipSelect_n = 1'b1;
        serial_in_line = ~serial_in_line;
    endtask
endmodule

// ---- adsp_pkg.sv ----
// adsp_pkg: constants shared by the serial port control block and its fifo
// assumes: master clock domain runs at 250 MHz, serial clock is host-made
package adsp_pkg;

    // ------------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------------
    localparam int WORD_BITS     = 24;
    localparam int CMD_BITS      = 8;
    localparam int DATA_BITS     = 20;
    localparam int DATA16_BITS   = 16;
    localparam int FLAG20_BITS   = 4;
    localparam int FLAG16_BITS   = 8;
    localparam int CNT_BITS      = 5;

    // ------------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------------
    localparam int CMD_WRITE_POS = 7;
    localparam int CMD_SEL_LSB   = 0;
    localparam int CMD_SEL_BITS  = 2;
    localparam logic [1:0] SEL_CONV = 2'h0;

    // ------------------------------------------------------------------
    // calibration registers, entries 1..3, with reset values
    // ------------------------------------------------------------------
    localparam int CAL_REGS = 4;
    localparam logic [WORD_BITS-1:0] CAL_RESET [CAL_REGS] = '{
        24'h000000, 24'h000000, 24'h800000, 24'h000000
    };

    // ------------------------------------------------------------------
    // timing and buffering
    // ------------------------------------------------------------------
    localparam int RESULT_PERIOD = 81920;
    localparam int PERIOD_BITS   = 17;
    localparam int FIFO_DEPTH    = 4;

    // ------------------------------------------------------------------
    // serial port states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ADSP_CMD   = 3'b001,
        ADSP_WRITE = 3'b010,
        ADSP_READ  = 3'b100
    } adsp_port_t;

endpackage

// ---- adsp_serial_port.sv ----
// adsp_serial_port: host serial port and result-ready signalling of the converter
// assumes: clk is the master clock, sclk is made by the host and may stop between frames
//
// Functional notes
// R01 - Reset restores every calibration register to its default and leaves the port awaiting a command.
// R02 - With chip select high and the mode pin low the serial output is released to high impedance.
// R03 - Only the host serial clock paces output shifting and input sampling.
// R04 - The serial input level is ignored whenever no word is being clocked in.
// R05 - Mode pin low selects the chip-select interface, high selects the three-wire interface.
// R06 - In conversion-read mode result ready goes low once every 81,920 master clocks with a new word.
// R07 - Result ready goes high after the word is shifted out, during reload, calibration and sleep.
// R08 - The word shifted out is conversion data or a calibration value, chosen by the prior command.
// R09 - In chip-select mode the output is high impedance whenever no word is being sent.
// R10 - Polarity select low gives unipolar coding, high gives bipolar coding.
// R11 - Results are offset binary or two's complement, MSB first, advanced on falling serial clock edges.
// R12 - Each conversion word is 24 bits: 16 or 20 data bits followed by identical flag bits.
// R13 - Flag bits are zero normally and all ones on overrange.
// R14 - The host starts a read only after result ready falls and ends it within the result period.
// R15 - Serial input bits are sampled on rising serial clock edges.
`timescale 1ns/100ps
module adsp_serial_port #(
    parameter int RESULT_PERIOD = adsp_pkg::RESULT_PERIOD
) (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               sclk,
    input  wire logic                               chipSelect_n,
    input  wire logic                               interface_mode_pin,
    input  wire logic                               serial_in_line,
    output logic                                    serial_out_line,
    output logic                                    serialOutEn_n,
    output logic                                    result_ready_n,
    input  wire logic                               polarity_select,
    input  wire logic                               res20Select,
    input  wire logic                               calBusy,
    input  wire logic                               sleepMode,
    input  wire logic [adsp_pkg::DATA_BITS-1:0]     convData,
    input  wire logic                               convOverrange,
    input  wire logic                               convValid,
    output logic                                    convReady,
    output logic [adsp_pkg::WORD_BITS-1:0]          calOffset,
    output logic [adsp_pkg::WORD_BITS-1:0]          calGain,
    output logic [adsp_pkg::WORD_BITS-1:0]          calDac
);
    localparam int FW = adsp_pkg::DATA_BITS + 1;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    adsp_pkg::adsp_port_t                       state_r;
    logic [adsp_pkg::CNT_BITS-1:0]              bitCnt_r;
    logic [adsp_pkg::CNT_BITS-1:0]              txCnt_r;
    logic [adsp_pkg::CMD_BITS-1:0]              cmdShift_r;
    logic [adsp_pkg::WORD_BITS-1:0]             wrShift_r;
    logic [adsp_pkg::WORD_BITS-1:0]             wrWord_r;
    logic [adsp_pkg::CMD_SEL_BITS-1:0]          sel_r;
    logic [adsp_pkg::CMD_SEL_BITS-1:0]          wrIdx_r;
    logic                                       convMode_r;
    logic                                       wrTgl_r;
    logic                                       doneTgl_r;
    logic                                       outBit_r;
    logic                                       portRst;
    logic [adsp_pkg::CMD_BITS-1:0]              cmdNxt;
    logic [adsp_pkg::WORD_BITS-1:0]             txWord;
    logic [adsp_pkg::WORD_BITS-1:0]             calReg_r [adsp_pkg::CAL_REGS];
    logic [adsp_pkg::WORD_BITS-1:0]             holdWord_r;
    logic [adsp_pkg::PERIOD_BITS-1:0]           periodCnt_r;
    logic                                       loadPend_r;
    logic                                       readyN_r;
    logic [2:0]                                 wrSync_r;
    logic [2:0]                                 doneSync_r;
    logic [1:0]                                 modeSync_r;
    logic [1:0]                                 polSync_r;
    logic [1:0]                                 resSync_r;
    logic                                       wrEvent;
    logic                                       doneEvent;
    logic                                       tick;
    logic [FW-1:0]                              fifoData;
    logic                                       fifoValid;
    logic                                       fifoPop;
    logic [adsp_pkg::DATA_BITS-1:0]             coded;
    logic                                       ovr;
    logic [adsp_pkg::WORD_BITS-1:0]             fmtWord;

    // ------------------------------------------------------------------
    // serial clock domain: port reset and input sampling
    // ------------------------------------------------------------------
    // chip select high frees the port only in chip-select mode
    assign portRst = rst | (chipSelect_n & ~interface_mode_pin); // R01 R05
    assign cmdNxt  = {cmdShift_r[adsp_pkg::CMD_BITS-2:0], serial_in_line};

    // rising edges sample the input; the input is only looked at in CMD/WRITE
    always_ff @(posedge sclk or posedge portRst) // R03 R15
    begin
        if (portRst)
        begin
            state_r    <= adsp_pkg::ADSP_CMD;
            bitCnt_r   <= '0;
            cmdShift_r <= '0;
            wrShift_r  <= '0;
            sel_r      <= adsp_pkg::SEL_CONV;
        end
        else
        begin
            case (state_r)
                adsp_pkg::ADSP_CMD:
                begin
                    cmdShift_r <= cmdNxt; // R04
                    if (bitCnt_r == adsp_pkg::CNT_BITS'(adsp_pkg::CMD_BITS - 1))
                    begin
                        bitCnt_r <= '0;
                        sel_r    <= cmdNxt[adsp_pkg::CMD_SEL_LSB +: adsp_pkg::CMD_SEL_BITS];
                        state_r  <= cmdNxt[adsp_pkg::CMD_WRITE_POS] ? adsp_pkg::ADSP_WRITE
                                                                     : adsp_pkg::ADSP_READ; // R08
                    end
                    else
                    begin
                        bitCnt_r <= bitCnt_r + 1'b1;
                    end
                end
                adsp_pkg::ADSP_WRITE,
                adsp_pkg::ADSP_READ:
                begin
                    if (state_r == adsp_pkg::ADSP_WRITE)
                    begin
                        wrShift_r <= {wrShift_r[adsp_pkg::WORD_BITS-2:0], serial_in_line}; // R04
                    end
                    if (bitCnt_r == adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS - 1))
                    begin
                        bitCnt_r <= '0;
                        state_r  <= adsp_pkg::ADSP_CMD;
                    end
                    else
                    begin
                        bitCnt_r <= bitCnt_r + 1'b1;
                    end
                end
                default:
                begin
                    bitCnt_r <= '0;
                    state_r  <= adsp_pkg::ADSP_CMD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // serial clock domain: events handed to the master clock
    // ------------------------------------------------------------------
    // only a true reset clears these; chip select must not lose a mode or toggle
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            convMode_r <= 1'b0;
            wrTgl_r    <= 1'b0;
            doneTgl_r  <= 1'b0;
            wrWord_r   <= '0;
            wrIdx_r    <= '0;
        end
        else
        begin
            if (state_r == adsp_pkg::ADSP_CMD &&
                bitCnt_r == adsp_pkg::CNT_BITS'(adsp_pkg::CMD_BITS - 1))
            begin
                convMode_r <= ~cmdNxt[adsp_pkg::CMD_WRITE_POS] &&
                    cmdNxt[adsp_pkg::CMD_SEL_LSB +: adsp_pkg::CMD_SEL_BITS] == adsp_pkg::SEL_CONV;
            end
            if (state_r == adsp_pkg::ADSP_WRITE &&
                bitCnt_r == adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS - 1))
            begin
                wrWord_r <= {wrShift_r[adsp_pkg::WORD_BITS-2:0], serial_in_line};
                wrIdx_r  <= sel_r;
                wrTgl_r  <= ~wrTgl_r;
            end
            if (state_r == adsp_pkg::ADSP_READ &&
                bitCnt_r == adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS - 1) && sel_r == adsp_pkg::SEL_CONV)
            begin
                doneTgl_r <= ~doneTgl_r; // R07
            end
        end
    end

    // ------------------------------------------------------------------
    // serial clock domain: output shifting
    // ------------------------------------------------------------------
    // held words stay still while the host reads them
    assign txWord = (sel_r == adsp_pkg::SEL_CONV) ? holdWord_r : calReg_r[sel_r]; // R08

    always_ff @(negedge sclk or posedge portRst) // R11
    begin
        if (portRst)
        begin
            txCnt_r  <= '0;
            outBit_r <= 1'b0;
        end
        else if (state_r == adsp_pkg::ADSP_READ)
        begin
            outBit_r <= txWord[adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS - 1) - txCnt_r];
            txCnt_r  <= txCnt_r + 1'b1;
        end
        else
        begin
            txCnt_r <= '0;
        end
    end

    assign serial_out_line = outBit_r;
    // three-wire mode keeps the line driven
    assign serialOutEn_n = interface_mode_pin ? 1'b0
                         : ~(state_r == adsp_pkg::ADSP_READ && !chipSelect_n); // R02 R09

    // ------------------------------------------------------------------
    // master clock domain: synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrSync_r   <= '0;
            doneSync_r <= '0;
            modeSync_r <= '0;
            polSync_r  <= '0;
            resSync_r  <= '0;
        end
        else
        begin
            wrSync_r   <= {wrSync_r[1:0], wrTgl_r};
            doneSync_r <= {doneSync_r[1:0], doneTgl_r};
            modeSync_r <= {modeSync_r[0], convMode_r};
            polSync_r  <= {polSync_r[0], polarity_select};
            resSync_r  <= {resSync_r[0], res20Select};
        end
    end

    assign wrEvent   = wrSync_r[2] ^ wrSync_r[1];
    assign doneEvent = doneSync_r[2] ^ doneSync_r[1];

    // ------------------------------------------------------------------
    // master clock domain: calibration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < adsp_pkg::CAL_REGS; i++)
            begin
                calReg_r[i] <= adsp_pkg::CAL_RESET[i]; // R01
            end
        end
        else if (wrEvent && wrIdx_r != adsp_pkg::SEL_CONV)
        begin
            calReg_r[wrIdx_r] <= wrWord_r;
        end
    end

    assign calOffset = calReg_r[1];
    assign calGain   = calReg_r[2];
    assign calDac    = calReg_r[3];

    // ------------------------------------------------------------------
    // master clock domain: result buffering and formatting
    // ------------------------------------------------------------------
    adsp_fifo #(
        .WIDTH (FW),
        .DEPTH (adsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inData   ({convOverrange, convData}),
        .inValid  (convValid),
        .inReady  (convReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    assign ovr     = fifoData[FW-1];
    // engine delivers offset binary; bipolar flips the sign bit
    assign coded   = fifoData[adsp_pkg::DATA_BITS-1:0] ^
                     {polSync_r[1], {(adsp_pkg::DATA_BITS-1){1'b0}}}; // R10 R11
    assign fmtWord = resSync_r[1]
                   ? {coded, {adsp_pkg::FLAG20_BITS{ovr}}}
                   : {coded[adsp_pkg::DATA_BITS-1 -: adsp_pkg::DATA16_BITS],
                      {adsp_pkg::FLAG16_BITS{ovr}}}; // R12 R13

    // ------------------------------------------------------------------
    // master clock domain: result period and ready line
    // ------------------------------------------------------------------
    assign tick    = (periodCnt_r == adsp_pkg::PERIOD_BITS'(RESULT_PERIOD - 1));
    assign fifoPop = tick & ~sleepMode;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            periodCnt_r <= '0;
        end
        else
        begin
            periodCnt_r <= (sleepMode || tick) ? '0 : periodCnt_r + 1'b1; // R06
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            holdWord_r <= '0;
            loadPend_r <= 1'b0;
        end
        else
        begin
            loadPend_r <= fifoPop & fifoValid;
            holdWord_r <= (fifoPop && fifoValid) ? fmtWord : holdWord_r;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            readyN_r <= 1'b1;
        end
        else if (calBusy || sleepMode || !modeSync_r[1] || (fifoPop && fifoValid) || doneEvent)
        begin
            readyN_r <= 1'b1; // R07
        end
        else if (loadPend_r)
        begin
            readyN_r <= 1'b0; // R06
        end
    end

    assign result_ready_n = readyN_r;

endmodule

// ---- adsp_serial_port_assertions.sv ----
// checker: port-level properties of adsp_serial_port
// assumes: bound to adsp_serial_port, sclk idles low between frames
`timescale 1ns/100ps
module adsp_serial_port_checker #(
    parameter int RESULT_PERIOD = 16
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sclk,
    input wire logic        chipSelect_n,
    input wire logic        interface_mode_pin,
    input wire logic        serial_in_line,
    input wire logic        serialOutEn_n,
    input wire logic        result_ready_n,
    input wire logic        calBusy,
    input wire logic        sleepMode,
    input wire logic [23:0] calOffset,
    input wire logic [23:0] calGain,
    input wire logic [23:0] calDac
);
    // ----
    // helper counters
    // ----
    logic [4:0] bitCnt_r;
    logic       wrCmd_r;
    int         gapCnt_r;

    // rising sclk edges since chip select fell
    always_ff @(posedge sclk or posedge chipSelect_n or posedge rst)
        if (rst || chipSelect_n) bitCnt_r <= 5'h0;
        else bitCnt_r <= bitCnt_r + 5'h1;

    always_ff @(posedge sclk or posedge rst)
        if (rst) wrCmd_r <= 1'b0;
        else if (bitCnt_r == 5'h0) wrCmd_r <= serial_in_line;

    // clk cycles since the last ready fall
    always_ff @(posedge clk or posedge rst)
        if (rst) gapCnt_r <= RESULT_PERIOD;
        else if ($fell(result_ready_n)) gapCnt_r <= 1;
        else if (gapCnt_r < RESULT_PERIOD) gapCnt_r <= gapCnt_r + 1;

    // ----
    // properties
    // ----
    out_release_a: assert property (@(posedge clk) disable iff (rst)
        !interface_mode_pin && chipSelect_n |-> serialOutEn_n) else $error("output not released");
    three_wire_a: assert property (@(posedge clk) disable iff (rst)
        interface_mode_pin |-> !serialOutEn_n) else $error("three-wire output not driven");
    enable_window_a: assert property (@(posedge sclk) disable iff (rst || chipSelect_n || interface_mode_pin)
        serialOutEn_n == !(bitCnt_r >= 5'h8 && !wrCmd_r)) else $error("output enable outside read window");
    cal_ready_a: assert property (@(posedge clk) disable iff (rst)
        calBusy |=> result_ready_n) else $error("ready low during calibration");
    sleep_ready_a: assert property (@(posedge clk) disable iff (rst)
        sleepMode |-> ##1 result_ready_n) else $error("ready low during sleep");
    fall_cause_a: assert property (@(posedge clk) disable iff (rst)
        $fell(result_ready_n) |-> !$past(calBusy) && !$past(sleepMode)) else $error("ready fell while forced");
    period_gap_a: assert property (@(posedge clk) disable iff (rst)
        $fell(result_ready_n) |-> gapCnt_r >= RESULT_PERIOD) else $error("ready fell early");
    reset_cal_a: assert property (@(posedge clk)
        $fell(rst) |-> calOffset == 24'h0 && calGain == 24'h800000 && calDac == 24'h0 && result_ready_n)
        else $error("reset state wrong");
endmodule

bind adsp_serial_port adsp_serial_port_checker #(.RESULT_PERIOD(RESULT_PERIOD)) u_chk (
    .clk(clk), .rst(rst), .sclk(sclk), .chipSelect_n(chipSelect_n),
    .interface_mode_pin(interface_mode_pin), .serial_in_line(serial_in_line),
    .serialOutEn_n(serialOutEn_n), .result_ready_n(result_ready_n),
    .calBusy(calBusy), .sleepMode(sleepMode),
    .calOffset(calOffset), .calGain(calGain), .calDac(calDac));

// ---- tb.sv ----
// tb: self-checking bench for adsp_serial_port
// assumes: host model drives the serial pins, bench plays the conversion engine
`timescale 1ns/100ps
module tb;
    localparam int PER = 512;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk;
    logic        chipSelect_n;
    logic        modePin = 1'b0;
    logic        sdi;
    logic        sdo;
    logic        sodEn_n;
    wire         sodWire;
    logic        ready_n;
    logic        pol = 1'b0;
    logic        res20 = 1'b1;
    logic        calBusy = 1'b0;
    logic        sleepMode = 1'b0;
    logic [19:0] convData = 20'h0;
    logic        ovr = 1'b0;
    logic        convValid = 1'b0;
    logic        convReady;
    logic [23:0] cal [1:3];
    int          errTotal = 0;
    int          cmpCount = 0;

    // ----
    // dut and host
    // ----
    adsp_serial_port #(.RESULT_PERIOD(PER)) u_dut (
        .clk(clk), .rst(rst), .sclk(sclk), .chipSelect_n(chipSelect_n), .interface_mode_pin(modePin),
        .serial_in_line(sdi), .serial_out_line(sdo), .serialOutEn_n(sodEn_n), .result_ready_n(ready_n),
        .polarity_select(pol), .res20Select(res20), .calBusy(calBusy), .sleepMode(sleepMode),
        .convData(convData), .convOverrange(ovr), .convValid(convValid), .convReady(convReady),
        .calOffset(cal[1]), .calGain(cal[2]), .calDac(cal[3]));
    adsp_host_model u_host (
        .sclk(sclk), .chipSelect_n(chipSelect_n), .serial_in_line(sdi), .serial_out_line(sodWire));
    assign sodWire = sodEn_n ? 1'bz : sdo;
    always #2 clk = ~clk;

    // ----
    // tasks
    // ----
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        cmpCount++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, s);
            errTotal++;
        end
    endtask

    task automatic finishTest;
        $display("errors %0d comparisons %0d", errTotal, cmpCount);
        if (errTotal == 0 && cmpCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic push(input logic [19:0] d, input logic o);
        @(negedge clk);
        convData = d;
        ovr = o;
        convValid = 1'b1;
        @(negedge clk);
        convValid = 1'b0;
    endtask

    task automatic waitFall;
        for (int n = 0; n < 3 * PER && ready_n !== 1'b0; n++)
            @(negedge clk);
    endtask

    function automatic logic [23:0] fmt(logic [19:0] d, logic o, logic p, logic w);
        logic [19:0] t;
        t = d ^ {p, 19'h0};
        return w ? {t, {4{o}}} : {t[19:4], {8{o}}};
    endfunction

    // ----
    // scenarios
    // ----
    task automatic testReset;
        for (int i = 1; i <= 3; i++)
            chk("calReset", adsp_pkg::CAL_RESET[i], cal[i]);
        chk("readyReset", 24'h1, 24'(ready_n));
        chk("sodIdle", 24'h1, 24'(sodEn_n));
    endtask

    task automatic testCal;
        logic [23:0] v;
        logic [23:0] rd;
        for (int i = 1; i <= 3; i++)
        begin
            v = 24'h5a3c01 ^ (24'(i) << 20);
            u_host.frame(8'h80 | 8'(i), v, rd);
            repeat (8) @(negedge clk);
            chk("calWrite", v, cal[i]);
            u_host.frame(8'(i), ~v, rd);
            chk("calRead", v, rd);
            chk("calKept", v, cal[i]);
        end
    endtask

    task automatic testConv;
        logic [19:0] d [5] = '{20'h80000, 20'h7ffff, 20'hfffff, 20'h00001, 20'h00000};
        logic [4:0]  o = 5'h14;
        logic [4:0]  pv = 5'h0c;
        logic [4:0]  wv = 5'h07;
        logic [23:0] rd;
        time         t0;
        u_host.frame(8'h00, 24'h0, rd);
        push(d[0], o[0]);
        for (int k = 0; k < 5; k++)
        begin
            waitFall;
            chk("readyFall", 24'h0, 24'(ready_n));
            if (k > 0)
                chk("period", 24'(PER), 24'(($time - t0) / 4));
            t0 = $time;
            if (k == 0)
            begin
                for (int j = 1; j < 5; j++)
                    push(d[j], o[j]);
                chk("fifoFull", 24'h0, 24'(convReady));
            end
            u_host.frame(8'h00, 24'hffffff, rd);
            chk("convWord", fmt(d[k], o[k], pv[k], wv[k]), rd);
            repeat (6) @(negedge clk);
            chk("readyDone", 24'h1, 24'(ready_n));
            pol = pv[(k + 1) % 5];
            res20 = wv[(k + 1) % 5];
        end
        chk("fifoFree", 24'h1, 24'(convReady));
    endtask

    task automatic testForce;
        for (int k = 0; k < 2; k++)
        begin
            push(20'h12345, 1'b0);
            waitFall;
            calBusy = (k == 0);
            sleepMode = (k == 1);
            repeat (3) @(negedge clk);
            chk("readyForced", 24'h1, 24'(ready_n));
            calBusy = 1'b0;
            sleepMode = 1'b0;
        end
    endtask

    task automatic testPins;
        logic [23:0] rd;
        chk("sodFloat", 24'h1, 24'(sodEn_n));
        modePin = 1'b1;
        repeat (3) @(negedge clk);
        chk("threeWire", 24'h0, 24'(sodEn_n));
        // offset register still holds the word written in testCal
        u_host.frame(8'h01, 24'h0, rd);
        chk("threeWireRead", 24'h4a3c01, rd);
    endtask

    // ----
    // run
    // ----
    initial
    begin
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        testReset;
        testCal;
        testConv;
        testForce;
        testPins;
        finishTest;
    end

    initial
    begin
        #300000;
        errTotal++;
        finishTest;
    end
endmodule
